// ---- rtl/lane_map_pkg.sv ----
/*
 * Shared constants for the lane sample mapper: widths, lane counts,
 * link mode codes and the lane layout enumeration.
 * Assumes a tool with SystemVerilog package support.
 */
package lane_map_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int SAMPLE_W   = 15;
  localparam int BYP_W      = 12;
  localparam int HALF_W     = 16;
  localparam int LANE_W     = 32;
  localparam int SIDE_LANES = 8;
  localparam int NUM_LANES  = 16;
  localparam int BYP_N      = 16;
  localparam int BYP_LANES  = 6;
  localparam int FIFO_DEPTH = 4;
  localparam int IN_W       = 4 * SIDE_LANES * SAMPLE_W
                              + 6 * SIDE_LANES + BYP_N * BYP_W;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [LANE_W-1:0]    LANE_IDLE   = 32'h0000_0000;
  localparam logic [NUM_LANES-1:0] ACTIVE_IDLE = 16'h0000;

  // ****************************************************************
  // link mode codes
  // ****************************************************************
  localparam logic [6:0] LM_11 = 7'h0B;
  localparam logic [6:0] LM_12 = 7'h0C;
  localparam logic [6:0] LM_13 = 7'h0D;
  localparam logic [6:0] LM_14 = 7'h0E;
  localparam logic [6:0] LM_15 = 7'h0F;
  localparam logic [6:0] LM_16 = 7'h10;
  localparam logic [6:0] LM_19 = 7'h13;
  localparam logic [6:0] LM_20 = 7'h14;
  localparam logic [6:0] LM_21 = 7'h15;
  localparam logic [6:0] LM_22 = 7'h16;
  localparam logic [6:0] LM_23 = 7'h17;
  localparam logic [6:0] LM_24 = 7'h18;
  localparam logic [6:0] LM_25 = 7'h19;
  localparam logic [6:0] LM_26 = 7'h1A;
  localparam logic [6:0] LM_27 = 7'h1B;
  localparam logic [6:0] LM_36 = 7'h24;
  localparam logic [6:0] LM_38 = 7'h26;
  localparam logic [6:0] LM_39 = 7'h27;
  localparam logic [6:0] LM_42 = 7'h2A;
  localparam logic [6:0] LM_43 = 7'h2B;
  localparam logic [6:0] LM_46 = 7'h2E;
  localparam logic [6:0] LM_47 = 7'h2F;
  localparam logic [6:0] LM_48 = 7'h30;
  localparam logic [6:0] LM_49 = 7'h31;
  localparam logic [6:0] LM_52 = 7'h34;
  localparam logic [6:0] LM_53 = 7'h35;
  localparam logic [6:0] LM_54 = 7'h36;
  localparam logic [6:0] LM_55 = 7'h37;
  localparam logic [6:0] LM_56 = 7'h38;
  localparam logic [6:0] LM_57 = 7'h39;
  localparam logic [6:0] LM_58 = 7'h3A;
  localparam logic [6:0] LM_59 = 7'h3B;
  localparam logic [6:0] LM_60 = 7'h3C;
  localparam logic [6:0] LM_61 = 7'h3D;
  localparam logic [6:0] LM_62 = 7'h3E;
  localparam logic [6:0] LM_63 = 7'h3F;
  localparam logic [6:0] LM_64 = 7'h40;
  localparam logic [6:0] LM_65 = 7'h41;
  localparam logic [6:0] LM_66 = 7'h42;
  localparam logic [6:0] LM_67 = 7'h43;
  localparam logic [6:0] LM_68 = 7'h44;
  localparam logic [6:0] LM_69 = 7'h45;
  localparam logic [6:0] LM_70 = 7'h46;
  localparam logic [6:0] LM_71 = 7'h47;

  // ****************************************************************
  // lane layouts
  // ****************************************************************
  typedef enum logic [2:0] {
    LAY_NONE, LAY_DUAL, LAY_PACK, LAY_SINGLE, LAY_SHARED,
    LAY_BYP_SINGLE, LAY_BYP_DUAL
  } layout_t;

endpackage : lane_map_pkg

// ---- rtl/lane_sample_mapper.sv ----
/*
 * Transport mapper: places converter words onto 16 lanes (A0-A7 as
 * lanes 0-7, B0-B7 as lanes 8-15) by link mode, behind a 4-word FIFO.
 * Assumes a serializer that takes one lane frame per i_lane_ready,
 * and a receiver set to the same link mode.
 */
// How it works
// R1: mode 12/53: A0-3 I, A4-7 Q, B likewise
// R2: mode 13 family: one lane holds I then Q
// R3: mode 14 family: A0 I, A1 Q, B alike
// R4: mode 15 family: two I, two Q lanes
// R5: mode 16: four I, four Q per channel
// R6: mode 19/42: even samples A, odd B, packed
// R7: mode 20/43: each channel packed on own side
// R8: mode 21/36: I on A0-A1, Q on B0-B1
// R9: mode 22/46: I on A0-A3, Q on B0-B3
// R10: mode 23 family: I A0, Q B0
// R11: mode 24 family: two I, two Q lanes
// R12: mode 25/52: adjacent lane pairs share flag
// R13: mode 26/54/63: four I, four Q, own flags
// R14: mode 27: eight I, eight Q, own flags
// R15: mode 47 equals mode 11 layout
// R16: word is sample then flag, octet 0 first
// R17: receiver must use the same link mode
`timescale 1ns/10ps
module lane_sample_mapper
  import lane_map_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_rst_n,
  // configuration
  input  wire logic [6:0]                         i_link_mode_select,
  // converter words, single channel uses the channel-a pair
  input  wire logic                               i_in_valid,
  input  wire logic [SIDE_LANES-1:0][SAMPLE_W-1:0] i_chan_a_inphase,
  input  wire logic [SIDE_LANES-1:0][SAMPLE_W-1:0] i_chan_a_quadrature,
  input  wire logic [SIDE_LANES-1:0][SAMPLE_W-1:0] i_chan_b_inphase,
  input  wire logic [SIDE_LANES-1:0][SAMPLE_W-1:0] i_chan_b_quadrature,
  input  wire logic [SIDE_LANES-1:0]              i_chan_a_overrange_0,
  input  wire logic [SIDE_LANES-1:0]              i_chan_a_overrange_1,
  input  wire logic [SIDE_LANES-1:0]              i_chan_b_overrange_0,
  input  wire logic [SIDE_LANES-1:0]              i_chan_b_overrange_1,
  input  wire logic [SIDE_LANES-1:0]              i_single_overrange_0,
  input  wire logic [SIDE_LANES-1:0]              i_single_overrange_1,
  input  wire logic [BYP_N-1:0][BYP_W-1:0]        i_bypass_sample,
  output      logic                               o_in_ready,
  // lane frames
  output      logic                               o_lane_valid,
  output      logic [NUM_LANES-1:0][LANE_W-1:0]   o_lane_word,
  input  wire logic                               i_lane_ready,
  // status
  output      logic [NUM_LANES-1:0]               o_lane_active,
  output      logic                               o_mode_error
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // decimated lane word: sample above, over-range flag in bit 0
  function automatic logic [HALF_W-1:0] dw(
    input logic [SAMPLE_W-1:0] s,
    input logic                f
  );
    return {s, f};
  endfunction : dw

  // four 12-bit samples packed msb first over three lanes
  function automatic logic [4*BYP_W-1:0] pack4(
    input logic [BYP_W-1:0] s0,
    input logic [BYP_W-1:0] s1,
    input logic [BYP_W-1:0] s2,
    input logic [BYP_W-1:0] s3
  );
    return {s0, s1, s2, s3};
  endfunction : pack4

  // ****************************************************************
  // input buffering
  // ****************************************************************
  logic [IN_W-1:0] in_word, f_data;
  logic            f_valid, load, pop;
  logic [SIDE_LANES-1:0][SAMPLE_W-1:0] f_ai, f_aq, f_bi, f_bq;
  logic [SIDE_LANES-1:0] f_chan_a_overrange_0, f_chan_a_overrange_1, f_chan_b_overrange_0, f_chan_b_overrange_1, f_so0, f_so1;
  logic [BYP_N-1:0][BYP_W-1:0] f_s;

  // one fifo word carries a whole frame of samples
  assign in_word = {i_chan_a_inphase, i_chan_a_quadrature,
                    i_chan_b_inphase, i_chan_b_quadrature,
                    i_chan_a_overrange_0, i_chan_a_overrange_1,
                    i_chan_b_overrange_0, i_chan_b_overrange_1,
                    i_single_overrange_0, i_single_overrange_1,
                    i_bypass_sample};
  assign {f_ai, f_aq, f_bi, f_bq, f_chan_a_overrange_0, f_chan_a_overrange_1, f_chan_b_overrange_0, f_chan_b_overrange_1,
          f_so0, f_so1, f_s} = f_data;

  sample_fifo #(
    .WIDTH (IN_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_valid (i_in_valid),
    .i_wr_data  (in_word),
    .o_wr_ready (o_in_ready),
    .o_rd_valid (f_valid),
    .o_rd_data  (f_data),
    .i_rd_ready (load)
  );

  // ****************************************************************
  // mode decode
  // ****************************************************************
  layout_t              lay;
  logic [3:0]           dec_n;
  logic [NUM_LANES-1:0] dec_mask;
  logic                 dec_err;

  link_mode_decode u_dec (
    .i_mode (i_link_mode_select),
    .o_lay  (lay),
    .o_n    (dec_n),
    .o_mask (dec_mask),
    .o_err  (dec_err)
  );

  // ****************************************************************
  // lane frame build
  // ****************************************************************
  logic [NUM_LANES-1:0][LANE_W-1:0] frame;

  // 16-bit frames sit in the upper half, so octet 0 is bits 31:24
  always_comb begin : build
    int cnt;
    int g;
    int j;
    logic [4*BYP_W-1:0] pk_a [2];
    logic [4*BYP_W-1:0] pk_b [2];
    logic [HALF_W-1:0]  zero_h;
    cnt    = int'(dec_n);
    g      = 0;
    j      = 0;
    zero_h = '0;
    pk_a   = '{default: '0};
    pk_b   = '{default: '0};
    frame  = '0;
    // bypass groups: single splits even/odd, dual splits by channel
    for (int k = 0; k < 2; k++) begin
      if (lay == LAY_BYP_SINGLE) begin
        pk_a[k] = pack4(f_s[8*k], f_s[8*k+2], f_s[8*k+4], f_s[8*k+6]); // R6
        pk_b[k] = pack4(f_s[8*k+1], f_s[8*k+3], f_s[8*k+5],
                        f_s[8*k+7]); // R6
      end else begin
        pk_a[k] = pack4(f_s[4*k], f_s[4*k+1], f_s[4*k+2], f_s[4*k+3]); // R7
        pk_b[k] = pack4(f_s[8+4*k], f_s[9+4*k], f_s[10+4*k],
                        f_s[11+4*k]); // R7
      end
    end
    for (int l = 0; l < SIDE_LANES; l++) begin
      g = l / 3;
      j = l % 3;
      unique case (lay)
        LAY_DUAL: begin
          // I lanes first, then Q lanes, per channel
          if (l < cnt) begin
            frame[l]   = {dw(f_ai[l], f_chan_a_overrange_0[l]), zero_h}; // R1 R3 R4 R5
            frame[l+8] = {dw(f_bi[l], f_chan_b_overrange_0[l]), zero_h}; // R1 R3 R4 R5
          end else if (l < 2*cnt) begin
            frame[l]   = {dw(f_aq[l-cnt], f_chan_a_overrange_1[l-cnt]), zero_h}; // R15
            frame[l+8] = {dw(f_bq[l-cnt], f_chan_b_overrange_1[l-cnt]), zero_h}; // R1
          end
        end
        LAY_PACK: begin
          // four octets: I word in octets 0-1, Q word in 2-3
          if (l == 0) begin
            frame[0] = {dw(f_ai[0], f_chan_a_overrange_0[0]), dw(f_aq[0], f_chan_a_overrange_1[0])}; // R2
            frame[8] = {dw(f_bi[0], f_chan_b_overrange_0[0]), dw(f_bq[0], f_chan_b_overrange_1[0])}; // R2
          end
        end
        LAY_SINGLE: begin
          // I on the A side, Q on the B side, one flag per sample
          if (l < cnt) begin
            frame[l]   = {dw(f_ai[l], f_so0[l]), zero_h}; // R8 R9 R10 R11
            frame[l+8] = {dw(f_aq[l], f_so1[l]), zero_h}; // R13 R14
          end
        end
        LAY_SHARED: begin
          // only four flags per component, one per lane pair
          frame[l]   = {dw(f_ai[l], f_so0[l/2]), zero_h}; // R12
          frame[l+8] = {dw(f_aq[l], f_so1[l/2]), zero_h}; // R12
        end
        LAY_BYP_SINGLE, LAY_BYP_DUAL: begin
          if (l < BYP_LANES) begin
            frame[l]   = {pk_a[g][47-16*j -: 16], zero_h}; // R6 R7
            frame[l+8] = {pk_b[g][47-16*j -: 16], zero_h}; // R6 R7
          end
        end
        LAY_NONE: begin
          frame[l] = LANE_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  logic                             valid_q, valid_d;
  logic [NUM_LANES-1:0][LANE_W-1:0] lanes_q, lanes_d;
  logic [NUM_LANES-1:0]             act_q, act_d;
  logic                             err_q, err_d;

  // a held frame stalls the fifo, which stalls the converter side
  assign load = !valid_q || i_lane_ready;
  assign pop  = f_valid && load;

  always_comb begin
    valid_d = valid_q;
    lanes_d = lanes_q;
    act_d   = dec_mask;
    err_d   = dec_err;
    if (load) begin
      valid_d = f_valid;
      if (f_valid) begin
        lanes_d = frame; // R16
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valid_q <= 1'b0;
      lanes_q <= {NUM_LANES{LANE_IDLE}};
      act_q   <= ACTIVE_IDLE;
      err_q   <= 1'b0;
    end else begin
      valid_q <= valid_d;
      lanes_q <= lanes_d;
      act_q   <= act_d;
      err_q   <= err_d;
    end
  end

  assign o_lane_valid  = valid_q;
  assign o_lane_word   = lanes_q;
  assign o_lane_active = act_q;
  assign o_mode_error  = err_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_dual4_q3;
    pop && lay == LAY_DUAL && dec_n == 4'h4 |=>
      o_lane_word[7] == {$past(f_aq[3]), $past(f_chan_a_overrange_1[3]), 16'h0000} &&
      o_lane_word[11] == {$past(f_bi[3]), $past(f_chan_b_overrange_0[3]), 16'h0000};
  endproperty
  a_dual4_q3: assert property (p_dual4_q3) else $error("dual x4 lane"); // R1

  property p_pack;
    pop && lay == LAY_PACK |=> o_lane_word[8] ==
      {$past(f_bi[0]), $past(f_chan_b_overrange_0[0]), $past(f_bq[0]), $past(f_chan_b_overrange_1[0])}
      && o_lane_word[1] == 32'h0;
  endproperty
  a_pack: assert property (p_pack) else $error("packed lane"); // R2

  property p_dual1;
    pop && lay == LAY_DUAL && dec_n == 4'h1 |=>
      o_lane_word[1][31:16] == {$past(f_aq[0]), $past(f_chan_a_overrange_1[0])};
  endproperty
  a_dual1: assert property (p_dual1) else $error("dual x1 lane"); // R3

  property p_dual2;
    pop && lay == LAY_DUAL && dec_n == 4'h2 |=>
      o_lane_word[2][31:16] == {$past(f_aq[0]), $past(f_chan_a_overrange_1[0])} &&
      o_lane_word[4] == 32'h0;
  endproperty
  a_dual2: assert property (p_dual2) else $error("dual x2 lane"); // R4

  property p_mode47;
    i_link_mode_select == LM_47 |=> o_lane_active == 16'h0F0F;
  endproperty
  a_mode47: assert property (p_mode47) else $error("mode 47 lanes"); // R15

  property p_byp_single;
    pop && lay == LAY_BYP_SINGLE |=> o_lane_word[1][31:16] ==
      {$past(f_s[2][7:0]), $past(f_s[4][11:4])};
  endproperty
  a_byp_single: assert property (p_byp_single) else $error("byp s"); // R6

  property p_byp_dual;
    pop && lay == LAY_BYP_DUAL |=> o_lane_word[13][31:16] ==
      {$past(f_s[14][3:0]), $past(f_s[15])};
  endproperty
  a_byp_dual: assert property (p_byp_dual) else $error("byp dual"); // R7

  property p_shared;
    pop && lay == LAY_SHARED |=> o_lane_word[3][16] == $past(f_so0[1])
      && o_lane_word[14][16] == $past(f_so1[3]);
  endproperty
  a_shared: assert property (p_shared) else $error("shared flag"); // R12

  property p_single8;
    pop && lay == LAY_SINGLE && dec_n == 4'h8 |=>
      o_lane_word[15][31:16] == {$past(f_aq[7]), $past(f_so1[7])};
  endproperty
  a_single8: assert property (p_single8) else $error("single x8"); // R14

  property p_single1;
    pop && lay == LAY_SINGLE && dec_n == 4'h1 |=>
      o_lane_word[8][31:16] == {$past(f_aq[0]), $past(f_so1[0])} &&
      o_lane_word[1] == 32'h0;
  endproperty
  a_single1: assert property (p_single1) else $error("single x1"); // R10

  property p_hold;
    o_lane_valid && !i_lane_ready |=> o_lane_valid && $stable(o_lane_word);
  endproperty
  a_hold: assert property (p_hold) else $error("frame not held"); // R16

endmodule : lane_sample_mapper

// ---- rtl/link_mode_decode.sv ----
/*
 * Decodes the link mode number into a lane layout, a per-group
 * sample count and the mask of lanes that carry data.
 * Assumes the mode input is static while the link runs.
 */
`timescale 1ns/10ps
module link_mode_decode
  import lane_map_pkg::*;
(
  // mode in
  input  wire logic [6:0]           i_mode,
  // decoded layout
  output      layout_t              o_lay,
  output      logic [3:0]           o_n,
  output      logic [NUM_LANES-1:0] o_mask,
  output      logic                 o_err
);

  logic [3:0] a_cnt;

  // alias modes fall onto the same layout as their base mode
  always_comb begin
    o_lay = LAY_NONE;
    o_n   = 4'h0;
    unique case (i_mode)
      LM_12, LM_16, LM_53: begin
        o_lay = LAY_DUAL; o_n = 4'h4;
      end
      LM_11, LM_15, LM_47, LM_55, LM_58: begin
        o_lay = LAY_DUAL; o_n = 4'h2;
      end
      LM_14, LM_49, LM_57, LM_60, LM_67: begin
        o_lay = LAY_DUAL; o_n = 4'h1;
      end
      LM_13, LM_39, LM_56, LM_59, LM_66, LM_68: begin
        o_lay = LAY_PACK; o_n = 4'h1;
      end
      LM_23, LM_38, LM_61, LM_64, LM_69, LM_71: begin
        o_lay = LAY_SINGLE; o_n = 4'h1;
      end
      LM_21, LM_36, LM_24, LM_48, LM_62, LM_65, LM_70: begin
        o_lay = LAY_SINGLE; o_n = 4'h2;
      end
      LM_22, LM_46, LM_26, LM_54, LM_63: begin
        o_lay = LAY_SINGLE; o_n = 4'h4;
      end
      LM_27: begin
        o_lay = LAY_SINGLE; o_n = 4'h8;
      end
      LM_25, LM_52: begin
        o_lay = LAY_SHARED; o_n = 4'h8;
      end
      LM_19, LM_42: begin
        o_lay = LAY_BYP_SINGLE; o_n = 4'h8;
      end
      LM_20, LM_43: begin
        o_lay = LAY_BYP_DUAL; o_n = 4'h8;
      end
      default: begin
        o_lay = LAY_NONE; o_n = 4'h0;
      end
    endcase
  end

  // lanes used on each side; both sides always match
  always_comb begin
    a_cnt = 4'h0;
    unique case (o_lay)
      LAY_DUAL:                     a_cnt = 4'(2 * o_n);
      LAY_PACK:                     a_cnt = 4'h1;
      LAY_SINGLE, LAY_SHARED:       a_cnt = o_n;
      LAY_BYP_SINGLE, LAY_BYP_DUAL: a_cnt = 4'(BYP_LANES);
      LAY_NONE:                     a_cnt = 4'h0;
    endcase
    o_mask = {2{8'((9'h001 << a_cnt) - 9'h001)}};
    o_err  = o_lay == LAY_NONE;
  end

endmodule : link_mode_decode

// ---- rtl/sample_fifo.sv ----
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output      logic             o_wr_ready,
  // drain side
  output      logic             o_rd_valid,
  output      logic [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             rdy_q, rdy_d, vld_q, vld_d;
  logic             push, pop;

  assign push       = i_wr_valid && rdy_q;
  assign pop        = vld_q && i_rd_ready;
  assign o_wr_ready = rdy_q;
  assign o_rd_valid = vld_q;
  assign o_rd_data  = mem[rp_q];

  // pointers and registered flags, so ready and valid are flop outputs
  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    rdy_d = cnt_d != FULL;
    vld_d = cnt_d != '0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
    end
  end

  // storage holds data only, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_wr_data;
    end
  end

endmodule : sample_fifo

// ---- tb/lane_rx_model.sv ----
/*
 * Receiver model: takes lane frames by valid/ready and keeps them.
 * Assumes the mapper's clock and reset; the bench stalls it at will.
 */
`timescale 1ns/10ps
module lane_rx_model
  import lane_map_pkg::*;
(
  // clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  // lane side
  input  wire logic                             i_valid,
  input  wire logic [NUM_LANES-1:0][LANE_W-1:0] i_word,
  output      logic                             o_ready,
  // control
  input  wire logic                             i_stall,
  output      int                               o_count
);
  // ****************************************************************
  // capture
  // ****************************************************************
  logic [NUM_LANES-1:0][LANE_W-1:0] mem [256];

  // ready moves only after an edge; the last 256 frames are kept, older ones overwritten
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_count <= 0;
    end else begin
      o_ready <= !i_stall;
      if (i_valid && o_ready) begin
        mem[o_count[7:0]] <= i_word;
        o_count <= o_count + 1;
      end
    end
  end
endmodule : lane_rx_model

// ---- tb/lane_sample_mapper_test.sv ----
/*
 * Self-checking bench: every link mode code, then fifo fill and drain.
 * Assumes lane_rx_model as the serializer side.
 */
`timescale 1ns/10ps
module lane_sample_mapper_test
  import lane_map_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                                clk, rst_n, vld, stall;
  logic                                lrdy, lvld, in_rdy, merr;
  logic [6:0]                          mode;
  logic [SIDE_LANES-1:0][SAMPLE_W-1:0] sm [4];
  logic [SIDE_LANES-1:0]               fl [6];
  logic [BYP_N-1:0][BYP_W-1:0]         bp;
  logic [NUM_LANES-1:0][LANE_W-1:0]    word;
  logic [NUM_LANES-1:0]                active;
  int                                  cnt, n_fail, n_tests, k, nr;

  lane_sample_mapper #(.DEPTH(FIFO_DEPTH)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_link_mode_select(mode),
    .i_in_valid(vld), .i_chan_a_inphase(sm[0]),
    .i_chan_a_quadrature(sm[1]), .i_chan_b_inphase(sm[2]),
    .i_chan_b_quadrature(sm[3]), .i_chan_a_overrange_0(fl[0]),
    .i_chan_a_overrange_1(fl[1]), .i_chan_b_overrange_0(fl[2]),
    .i_chan_b_overrange_1(fl[3]), .i_single_overrange_0(fl[4]),
    .i_single_overrange_1(fl[5]), .i_bypass_sample(bp),
    .o_in_ready(in_rdy), .o_lane_valid(lvld), .o_lane_word(word),
    .i_lane_ready(lrdy), .o_lane_active(active), .o_mode_error(merr));

  lane_rx_model rx (
    .i_clk(clk), .i_rst_n(rst_n), .i_valid(lvld), .i_word(word),
    .o_ready(lrdy), .i_stall(stall), .o_count(cnt));

  // ****************************************************************
  // data patterns and expected lanes
  // ****************************************************************
  // samples never zero, so an all-zero lane means unused
  function automatic logic [14:0] smp(int k, int c, int i);
    return 15'h4000 | 15'(k * 32 + c * 8 + i);
  endfunction : smp
  function automatic logic fb(int k, int f, int j);
    logic [7:0] v;
    v = 8'hA5 ^ 8'(k * 13) ^ 8'(f * 57);
    return v[j];
  endfunction : fb
  function automatic logic [11:0] byp(int k, int p);
    return 12'h800 | 12'(k * 16 + p);
  endfunction : byp
  function automatic logic [31:0] dw(int k, int c, int i, int f, int j);
    return {smp(k, c, i), fb(k, f, j), 16'h0000};
  endfunction : dw

  function automatic logic [31:0] ew(logic [6:0] m, int k, int l);
    int s;
    int i;
    int n;
    int p[4];
    logic [47:0] g;
    s = l / 8;
    i = l % 8;
    ew = 32'h0000_0000;
    case (m)
      LM_12, LM_53, LM_16: n = 4;
      LM_11, LM_47, LM_15, LM_55, LM_58: n = 2;
      LM_14, LM_49, LM_57, LM_60, LM_67: n = 1;
      default: n = 0;
    endcase
    if (i < n) ew = dw(k, 2 * s, i, 2 * s, i);
    else if (i < 2 * n) ew = dw(k, 2 * s + 1, i - n, 2 * s + 1, i - n);
    case (m)
      LM_21, LM_36, LM_24, LM_48, LM_62, LM_65, LM_70: n = 2;
      LM_22, LM_46, LM_26, LM_54, LM_63: n = 4;
      LM_23, LM_38, LM_61, LM_64, LM_69, LM_71: n = 1;
      LM_27, LM_25, LM_52: n = 8;
      default: n = 0;
    endcase
    if (i < n) ew = dw(k, s, i, 4 + s, m inside {LM_25, LM_52} ? i / 2 : i);
    if (i == 0 && m inside {LM_13, LM_39, LM_56, LM_59, LM_66, LM_68})
      ew = {smp(k, 2 * s, 0), fb(k, 2 * s, 0),
            smp(k, 2 * s + 1, 0), fb(k, 2 * s + 1, 0)};
    if (i < 6 && m inside {LM_19, LM_42, LM_20, LM_43}) begin
      for (int q = 0; q < 4; q++)
        p[q] = m inside {LM_19, LM_42} ? 8 * (i / 3) + 2 * q + s
                                        : 4 * (i / 3) + q + 8 * s;
      g = {byp(k, p[0]), byp(k, p[1]), byp(k, p[2]), byp(k, p[3])};
      ew = {g[47 - 16 * (i % 3) -: 16], 16'h0000};
    end
  endfunction : ew

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic drv(int k);
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 4; c++) sm[c][i] <= smp(k, c, i);
      for (int f = 0; f < 6; f++) fl[f][i] <= fb(k, f, i);
    end
    for (int p = 0; p < BYP_N; p++) bp[p] <= byp(k, p);
  endtask : drv

  // valid held until an edge that samples ready high
  task automatic send(int k);
    int w;
    drv(k);
    vld <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (in_rdy !== 1'b1 && w < 20);
    vld <= 1'b0;
  endtask : send

  task automatic wait_rx(int n);
    int w;
    w = 0;
    while (cnt < n && w < 40) begin
      @(posedge clk);
      w++;
    end
    chk("frame count", n, cnt);
  endtask : wait_rx

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("reset outputs", 19'h40000, {in_rdy, lvld, merr, active});
  endtask : t_reset

  // every code 0..127; unknown codes must give no lanes and an error
  task automatic t_modes();
    logic [15:0] ea;
    for (int m = 0; m < 128; m++) begin
      mode <= 7'(m);
      repeat (3) @(posedge clk);
      for (int l = 0; l < 16; l++) ea[l] = ew(7'(m), k, l) != 32'h0;
      chk("lane active", ea, active);
      chk("mode error", ea == 16'h0, merr);
      send(k);
      nr++;
      wait_rx(nr);
      for (int l = 0; l < 16; l++)
        chk("lane word", ew(7'(m), k, l), rx.mem[nr - 1][l]);
      k++;
    end
  endtask : t_modes

  // fill against a stalled receiver until refused, then drain in order
  task automatic t_fifo();
    int acc;
    mode <= LM_27;
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    acc = 0;
    drv(k);
    vld <= 1'b1;
    do begin
      @(posedge clk);
      if (in_rdy === 1'b1) acc++;
      drv(k + acc);
    end while (in_rdy === 1'b1 && acc < 12);
    vld <= 1'b0;
    chk("accepted", FIFO_DEPTH + 1, acc);
    chk("frame held", 1, lvld);
    stall <= 1'b0;
    wait_rx(nr + acc);
    for (int n = 0; n < acc; n++)
      for (int l = 0; l < 16; l += 15)
        chk("drained word", ew(LM_27, k + n, l), rx.mem[nr + n][l]);
    chk("empty", 0, lvld);
  endtask : t_fifo

  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ****************************************************************
  // run
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    stall = 1'b0;
    mode = LM_12;
    k = 1;
    nr = 0;
    n_fail = 0;
    n_tests = 0;
    drv(0);
    repeat (4) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    @(posedge clk);
    t_modes();
    t_fifo();
    results();
  end

  // about six times the expected run
  initial begin
    #(50 * 6000);
    n_fail++;
    results();
  end
endmodule : lane_sample_mapper_test
